// ===== shared/ocf_cfg.svh
// Purpose: Offsets, field positions and reset values of the OTP config store
// Assumes: Byte registers, one per aligned AHB word (byte address = index * 4)
// Notes: Definitions only
`ifndef OCF_CFG_SVH
`define OCF_CFG_SVH

// ------------------------------------------------------------
// Register indices
// ------------------------------------------------------------
`define OCF_IDX_PID_HIGH 8'h15
`define OCF_IDX_POWER 8'h16
`define OCF_IDX_ATTR 8'h17
`define OCF_IDX_REL_MAJOR 8'h18
`define OCF_IDX_REL_MINOR 8'h19
`define OCF_IDX_PURGE 8'h1a
`define OCF_IDX_FLAGS_A 8'h1d
`define OCF_IDX_FLAGS_B 8'h1e
`define OCF_NUM_FIELD_BYTES 6

// ------------------------------------------------------------
// Field positions and masks
// ------------------------------------------------------------
`define OCF_ATTR_WR_MASK 8'h0f
`define OCF_ATTR_MODE_LO 0
`define OCF_ATTR_WAKE_VALID 2
`define OCF_ATTR_WAKE_EN 3
`define OCF_PURGE_WR_MASK 8'h1e
`define OCF_PURGE_TX_OPEN 1
`define OCF_PURGE_TX_CLOSE 2
`define OCF_PURGE_RX_OPEN 3
`define OCF_PURGE_RX_CLOSE 4
`define OCF_FLAGS_A_WR_MASK 8'h9f
`define OCF_FLAG_PID 1
`define OCF_FLAG_POWER 2
`define OCF_FLAG_ATTR 3
`define OCF_FLAG_RELEASE 4
`define OCF_FLAG_PURGE 5
`define OCF_BM_ALWAYS_ONE 7
`define OCF_BM_SELF_POWER 6
`define OCF_BM_REMOTE_WAKE 5
`define OCF_MODE_BUS 2'h0
`define OCF_MODE_INVALID 2'h3
`define OCF_POWER_MIN 8'h01
`define OCF_POWER_MAX 8'hfa
`define OCF_RESET_BYTE 8'h00
`define OCF_HTRANS_NONSEQ 2'h2
`define OCF_HTRANS_SEQ 2'h3
`define OCF_HSIZE_WORD 3'h2

`endif

// ===== shared/ocf_pkg.sv
// Purpose: Types shared by the OTP config store and its users
// Assumes: Widths fixed by the byte register map
// Notes: Constants live in ocf_cfg.svh
package ocf_pkg;

  // ------------------------------------------------------------
  // Descriptor values seen by the USB side
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] pid_high;
    logic [7:0] max_power;
    logic power_in_range;
    logic [7:0] bm_attributes;
    logic mode_invalid;
    logic [7:0] rel_major;
    logic [7:0] rel_minor;
  } ocf_desc_type;

  // ------------------------------------------------------------
  // Whole state of the store
  // ------------------------------------------------------------
  typedef struct packed {
    logic [5:0][7:0] staged;
    logic [5:0] entered;
    logic [5:0][7:0] otp;
    logic [7:0] flags_a;
    logic [7:0] flags_b;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [31:0] rdata;
    logic rx_purge;
    logic tx_purge;
    ocf_desc_type desc;
  } ocf_state_type;

endpackage

// ===== hdl/ocf_top.sv
// Purpose: OTP store for USB descriptor fields, purge control and burn flags
// Assumes: Single AHB-Lite slave, zero wait states, 25 MHz ref_clk
// Notes: OTP cells modelled as flops; burn happens on setting a flag byte B bit
//
// Function
// - Report power byte as bMaxPower, 2 mA units
// - Advertise wake setting in D5 only if valid
// - Wake enable bit: 0 disabled, 1 enabled
// - Mode 00 bus, 01/10 self, 11 invalid
// - Close event purges RX/TX when enabled
// - Open event purges RX/TX when enabled
// - Use OTP value only when flag set
// - Burned field refuses further programming
// - Unentered parts of burned field become zero
// - Flag byte A bit map at 0x1d
// - Flag byte B bit map at 0x1e
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ns
`include "ocf_cfg.svh"

module ocf_top
  import ocf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic port_open_evt,
  input wire logic port_close_evt,
  output logic rx_purge,
  output logic tx_purge,
  output ocf_desc_type desc
);

  ocf_state_type st_r;
  ocf_state_type st_nxt;

  // ------------------------------------------------------------
  // Field byte to burn flag (flag byte B)
  // ------------------------------------------------------------
  function automatic logic [2:0] ocf_flag_of(input int unsigned i);
    logic [2:0] pos;
    pos = 3'(`OCF_FLAG_PID);
    unique case (i)
      0: pos = 3'(`OCF_FLAG_PID);
      1: pos = 3'(`OCF_FLAG_POWER);
      2: pos = 3'(`OCF_FLAG_ATTR);
      3: pos = 3'(`OCF_FLAG_RELEASE);
      4: pos = 3'(`OCF_FLAG_RELEASE);
      5: pos = 3'(`OCF_FLAG_PURGE);
      default: pos = 3'(`OCF_FLAG_PID);
    endcase
    return pos;
  endfunction

  // Reserved bits held at zero whatever software writes
  function automatic logic [7:0] ocf_wr_mask(input int unsigned i);
    logic [7:0] m;
    m = 8'hff;
    if (i == 2) begin
      m = `OCF_ATTR_WR_MASK;
    end else if (i == 5) begin
      m = `OCF_PURGE_WR_MASK;
    end
    return m;
  endfunction

  logic addr_ok;
  logic [7:0] a_idx;
  logic [5:0][7:0] eff;
  logic [5:0][7:0] eff_new;
  logic [7:0] new_b;
  logic [7:0] attr;
  logic [7:0] purge;
  logic [7:0] bm;
  logic [7:0] rd_byte;

  assign a_idx = haddr[9:2];
  assign addr_ok = hsel && hready && (htrans == `OCF_HTRANS_NONSEQ || htrans == `OCF_HTRANS_SEQ);

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    new_b = 8'h00;
    rd_byte = 8'h00;
    // Effective values: OTP copy only once burned, shadow otherwise
    for (int i = 0; i < `OCF_NUM_FIELD_BYTES; i++) begin
      eff[i] = st_r.flags_b[ocf_flag_of(i)] ? st_r.otp[i] : st_r.staged[i];
    end
    attr = eff[2];
    purge = eff[5];

    // Data phase of a write
    if (st_r.wr_pend) begin
      if (st_r.wr_idx >= `OCF_IDX_PID_HIGH && st_r.wr_idx <= `OCF_IDX_PURGE) begin
        for (int i = 0; i < `OCF_NUM_FIELD_BYTES; i++) begin
          if (st_r.wr_idx == 8'(`OCF_IDX_PID_HIGH + i) && !st_r.flags_b[ocf_flag_of(i)]) begin
            st_nxt.staged[i] = hwdata[7:0] & ocf_wr_mask(i);
            st_nxt.entered[i] = 1'b1;
          end
        end
      end else if (st_r.wr_idx == `OCF_IDX_FLAGS_A) begin
        // Flags are one-time: set only, never cleared
        st_nxt.flags_a = st_r.flags_a | (hwdata[7:0] & `OCF_FLAGS_A_WR_MASK);
      end else if (st_r.wr_idx == `OCF_IDX_FLAGS_B) begin
        new_b = hwdata[7:0] & ~st_r.flags_b;
        st_nxt.flags_b = st_r.flags_b | hwdata[7:0];
        for (int i = 0; i < `OCF_NUM_FIELD_BYTES; i++) begin
          if (new_b[ocf_flag_of(i)]) begin
            // Half-entered release pair burns zero in the missing byte
            st_nxt.otp[i] = st_r.entered[i] ? st_r.staged[i] : `OCF_RESET_BYTE;
          end
        end
      end
    end

    // Read right behind a write sees it: that write is still in its data phase
    for (int i = 0; i < `OCF_NUM_FIELD_BYTES; i++) begin
      eff_new[i] = st_nxt.flags_b[ocf_flag_of(i)] ? st_nxt.otp[i] : st_nxt.staged[i];
    end

    // Address phase
    st_nxt.wr_pend = addr_ok && hwrite && haddr[1:0] == 2'h0;
    st_nxt.wr_idx = a_idx;
    if (addr_ok && !hwrite && haddr[1:0] == 2'h0) begin
      if (a_idx >= `OCF_IDX_PID_HIGH && a_idx <= `OCF_IDX_PURGE) begin
        rd_byte = eff_new[3'(a_idx - `OCF_IDX_PID_HIGH)];
      end else if (a_idx == `OCF_IDX_FLAGS_A) begin
        rd_byte = st_nxt.flags_a;
      end else if (a_idx == `OCF_IDX_FLAGS_B) begin
        rd_byte = st_nxt.flags_b;
      end
    end
    st_nxt.rdata = {24'h000000, rd_byte};

    // Purge pulses on port events
    st_nxt.rx_purge = (port_close_evt && purge[`OCF_PURGE_RX_CLOSE])
      || (port_open_evt && purge[`OCF_PURGE_RX_OPEN]);
    st_nxt.tx_purge = (port_close_evt && purge[`OCF_PURGE_TX_CLOSE])
      || (port_open_evt && purge[`OCF_PURGE_TX_OPEN]);

    // Configuration descriptor attributes
    bm = 8'h00;
    bm[`OCF_BM_ALWAYS_ONE] = 1'b1;
    bm[`OCF_BM_SELF_POWER] = attr[`OCF_ATTR_MODE_LO +: 2] != `OCF_MODE_BUS
      && attr[`OCF_ATTR_MODE_LO +: 2] != `OCF_MODE_INVALID;
    bm[`OCF_BM_REMOTE_WAKE] = attr[`OCF_ATTR_WAKE_VALID] && attr[`OCF_ATTR_WAKE_EN];
    st_nxt.desc.bm_attributes = bm;
    st_nxt.desc.mode_invalid = attr[`OCF_ATTR_MODE_LO +: 2] == `OCF_MODE_INVALID;
    st_nxt.desc.pid_high = eff[0];
    st_nxt.desc.max_power = eff[1];
    st_nxt.desc.power_in_range = eff[1] >= `OCF_POWER_MIN && eff[1] <= `OCF_POWER_MAX;
    st_nxt.desc.rel_major = eff[3];
    st_nxt.desc.rel_minor = eff[4];
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Zero wait states: every access completes in one data phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_r.rdata;
  assign rx_purge = st_r.rx_purge;
  assign tx_purge = st_r.tx_purge;
  assign desc = st_r.desc;

endmodule

// ===== verification/ocf_port_peer.sv
// Purpose: Serial port side that opens and closes the port and counts purges
// Assumes: One request bit set for one cycle, bit 1 open, bit 0 close
// Notes: Counters wrap at 255
`timescale 1ns/1ns
module ocf_port_peer (
  input logic ref_clk,
  input logic [1:0] port_req,
  input logic rx_purge,
  input logic tx_purge,
  output logic port_open_evt = 1'b0,
  output logic port_close_evt = 1'b0,
  output logic [7:0] rx_seen = 8'h0,
  output logic [7:0] tx_seen = 8'h0
);
  // Purges are unknown before the first reset edge, so only a clean 1 counts
  always @(posedge ref_clk) begin
    {port_open_evt, port_close_evt} <= port_req;
    rx_seen <= rx_seen + 8'(rx_purge === 1'b1);
    tx_seen <= tx_seen + 8'(tx_purge === 1'b1);
  end
endmodule

// ===== verification/ocf_top_chk.sv
// Purpose: Port checks on the OTP config store
// Assumes: One clock, reset active high
// Notes: Bound into every ocf_top
`timescale 1ns/1ns
module ocf_top_chk
  import ocf_pkg::*;
(
  input logic ref_clk,
  input logic rst,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [31:0] hrdata,
  input logic port_open_evt,
  input logic port_close_evt,
  input logic rx_purge,
  input logic tx_purge,
  input ocf_desc_type desc
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  sequence rd_unmapped;
    hsel && htrans[1] && !hwrite && haddr[9:2] > 8'h1e;
  endsequence
  unmapped_read_a: assert property (rd_unmapped |=> hrdata == 32'h0) else $error("unmapped read");
  rdata_byte_a: assert property (hrdata[31:8] == 24'h0) else $error("read upper bits");
  rx_cause_a: assert property (rx_purge |-> $past(port_open_evt) || $past(port_close_evt))
    else $error("rx purge");
  tx_cause_a: assert property (tx_purge |-> $past(port_open_evt) || $past(port_close_evt))
    else $error("tx purge");
  power_range_a: assert property (desc.power_in_range == (desc.max_power inside {[8'h01:8'hfa]}))
    else $error("power range");
  self_mode_a: assert property (desc.mode_invalid |-> !desc.bm_attributes[6]) else $error("mode 11");
  top_bit_a: assert property (!$past(rst) |-> desc.bm_attributes[7]) else $error("bm top bit");
  bm_low_a: assert property (desc.bm_attributes[4:0] == 5'h0) else $error("bm low bits");
endmodule
bind ocf_top ocf_top_chk ocf_top_chk_inst (.*);

// ===== verification/test_otp_usb_config_fields.sv
// Purpose: Self-checking bench for the OTP config store
// Assumes: AHB-Lite single slave, ref_clk 40 ns
// Notes: Burn runs last, burned fields stay locked
`timescale 1ns/1ns
module test_otp_usb_config_fields import ocf_pkg::*;;
  logic ref_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic hreadyout, hresp, port_open_evt, port_close_evt, rx_purge, tx_purge;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0, port_req = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [7:0] rx_seen, tx_seen, f;
  logic [7:0] ri [9] = '{8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1d, 8'h1e, 8'h1f};
  logic [7:0] fb [6] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h10, 8'h20};
  logic [7:0] fv [6] = '{8'h5a, 8'h32, 8'h06, 8'h12, 8'h00, 8'h0a};
  ocf_desc_type desc;
  int n_errors = 0, n_checks = 0;
  always #20 ref_clk = ~ref_clk;
  ocf_top ocf_top_inst (.hready(hreadyout), .*);
  ocf_port_peer ocf_port_peer_inst (.*);
  task automatic give_verdict(input int e);
    n_errors += e;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) n_errors++;
    if (g !== e) $display("[FAIL] %s expected %h seen %h", s, e, g);
  endtask
  // Reads compare against d; the wait never trusts a fixed latency
  task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 22'h0, i, 2'h0};
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk);
      for (int j = 0; j < 99 && hreadyout !== 1'b1; j++) @(posedge ref_clk);
      if (hreadyout !== 1'b1) give_verdict(1);
      if (k == 0) {hsel, htrans, hwdata} <= {3'h0, 24'h0, d};
    end
    if (!w) chk($sformatf("reg %h", i), {24'h0, d}, hrdata);
  endtask
  task automatic pulse(input logic [1:0] e);
    port_req <= e;
    @(posedge ref_clk);
    port_req <= 2'h0;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic t_reset;
    foreach (ri[k]) bus(1'b0, ri[k], 8'h0);
    chk("bm", 32'h80, {24'h0, desc.bm_attributes});
    $display("reset test done");
  endtask
  task automatic t_desc;
    logic [7:0] p;
    for (int v = 0; v < 16; v++) begin
      p = 8'hf9 + 8'(v);
      bus(1'b1, 8'h16, p);
      bus(1'b1, 8'h17, 8'(v));
      bus(1'b0, 8'h17, 8'(v));
      chk("bm", {25'h1, v[1] ^ v[0], v[3] & v[2], 5'h0}, {24'h0, desc.bm_attributes});
      chk("power", {22'h0, p, p != 8'h0 && p < 8'hfb, v[1] & v[0]},
        {22'h0, desc.max_power, desc.power_in_range, desc.mode_invalid});
    end
    $display("descriptor test done");
  endtask
  task automatic t_purge;
    logic [7:0] r, t;
    for (int v = 0; v < 16; v++) begin
      bus(1'b1, 8'h1a, 8'(v * 2));
      {r, t} = {rx_seen, tx_seen};
      pulse(2'h2);
      chk("open", {16'h0, r + v[2], t + v[0]}, {16'h0, rx_seen, tx_seen});
      pulse(2'h1);
      chk("close", {16'h0, r + v[2] + v[3], t + v[0] + v[1]}, {16'h0, rx_seen, tx_seen});
    end
    $display("purge test done");
  endtask
  task automatic t_burn;
    f = 8'h0;
    bus(1'b1, 8'h1d, 8'h9f);
    bus(1'b0, 8'h1d, 8'h9f);
    for (int k = 0; k < 6; k++) begin
      if (k != 4) bus(1'b1, ri[k], fv[k]);
      f = f | fb[k];
      bus(1'b1, 8'h1e, fb[k]);
      bus(1'b1, ri[k], 8'h02);
      bus(1'b0, ri[k], fv[k]);
      bus(1'b0, 8'h1e, f);
    end
    chk("pid", 32'h5a, {24'h0, desc.pid_high});
    chk("release", 32'h1200, {16'h0, desc.rel_major, desc.rel_minor});
    chk("hresp", 32'h0, {31'h0, hresp});
    $display("burn test done");
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset;
    t_desc;
    t_purge;
    t_burn;
    give_verdict(0);
  end
endmodule
